// ==== rtl/parallel_io_change_detect.sv ====
// Parallel I/O block: four emulated interfaces, change detect, APB slave.
// Assumes an APB master on clk; pins and straps are asynchronous.
`timescale 1ns/100ps
module parallel_io_change_detect
	import pio_pkg::*;
(
	// Clock and control
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// I/O lines
	input  wire logic [NUM_LINES-1:0] io_i,
	output logic      [NUM_LINES-1:0] io_o,
	output logic      [NUM_LINES-1:0] io_oe_n,
	// Static switches and straps
	input  wire logic                 sw_sel1_i,
	input  wire logic                 sw_sel2_i,
	input  wire logic                 half_width_i,
	input  wire logic                 detect_all_i,
	// Stack signal groups
	input  wire logic [3:0]           grp_clk_i,
	input  wire logic [3:0]           grp_idsel_i,
	output logic                      sel_clk_o,
	output logic                      sel_idsel_o,
	output logic      [3:0]           int_o,
	output logic      [3:0]           int_oe_n,
	// Interrupt level
	output logic                      irq
);
	logic [NUM_LINES+3:0] sync_q;
	logic [NUM_LINES-1:0] lines_sync;
	logic [1:0]           sel_idx;
	logic                 half_mode;
	logic                 all_mode;
	logic [NUM_LINES-1:0] flags;
	logic [NUM_LINES-1:0] det_en;
	logic [NUM_LINES-1:0] clr;
	logic [NUM_LINES-1:0] dir_all;

	bus_state_t  bus_reg;
	bus_state_t  bus_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        err_reg;
	logic        err_next;
	logic [3:0]  dir_reg    [NUM_GROUPS];
	logic [3:0]  dir_next   [NUM_GROUPS];
	logic [23:0] latch_reg  [NUM_GROUPS];
	logic [23:0] latch_next [NUM_GROUPS];
	logic [NUM_LINES-1:0] en_reg;
	logic [NUM_LINES-1:0] en_next;
	logic        irq_reg;
	logic        irq_next;
	logic [4:0]  idx;
	logic        wr_fire;
	logic        rd_take;
	logic [23:0] lane_m;

	// Input direction mask of one group
	function automatic logic [23:0] dir_lines(input logic [3:0] d);
		return {{4{d[DIR_CHI]}}, {4{d[DIR_CLO]}}, {8{d[DIR_B]}}, {8{d[DIR_A]}}};
	endfunction

	// Spread a byte onto upper nibble lines of two groups
	function automatic logic [NUM_LINES-1:0] chi_map(input logic [7:0] b, input logic hi);
		logic [NUM_LINES-1:0] v;
		v = '0;
		if (hi) begin
			v[2*GROUP_LINES+OFS_CHI +: 4] = b[3:0];
			v[3*GROUP_LINES+OFS_CHI +: 4] = b[7:4];
		end else begin
			v[OFS_CHI +: 4]             = b[3:0];
			v[GROUP_LINES+OFS_CHI +: 4] = b[7:4];
		end
		return v;
	endfunction

	// Gather upper nibble lines of two groups into a byte
	function automatic logic [7:0] chi_get(input logic [NUM_LINES-1:0] v, input logic hi);
		if (hi) begin
			return {v[3*GROUP_LINES+OFS_CHI +: 4], v[2*GROUP_LINES+OFS_CHI +: 4]};
		end
		return {v[GROUP_LINES+OFS_CHI +: 4], v[OFS_CHI +: 4]};
	endfunction

	// Lines that may detect changes in the selected variant
	function automatic logic [NUM_LINES-1:0] cap_mask(input logic half, input logic all);
		if (half && all) begin
			return {48'h0, 48'hFFFFFFFFFFFF};
		end else if (half) begin
			return '0;
		end
		return chi_map(8'hFF, 1'b0) | chi_map(8'hFF, 1'b1);
	endfunction

	sync_2ff #(
		.W(NUM_LINES + 4)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.d   ({detect_all_i, half_width_i, sw_sel2_i, sw_sel1_i, io_i}),
		.q   (sync_q)
	);

	assign lines_sync = sync_q[NUM_LINES-1:0];
	assign sel_idx    = sync_q[NUM_LINES+1:NUM_LINES];
	assign half_mode  = sync_q[NUM_LINES+2];
	assign all_mode   = sync_q[NUM_LINES+3];

	// Stack signal group selection
	assign sel_clk_o   = grp_clk_i[sel_idx];
	assign sel_idsel_o = grp_idsel_i[sel_idx];
	assign int_o       = 4'h0;
	always_comb begin
		for (int j = 0; j < 4; j++) begin
			int_oe_n[j] = !(irq_reg && (sel_idx == 2'(j)));
		end
	end

	always_comb begin
		for (int g = 0; g < NUM_GROUPS; g++) begin
			dir_all[g*GROUP_LINES +: GROUP_LINES] = dir_lines(dir_reg[g]);
		end
	end

	assign det_en = en_reg & dir_all & cap_mask(half_mode, all_mode);

	change_detector u_det (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.line_lvl (lines_sync),
		.det_en   (det_en),
		.clr      (clr),
		.flag     (flags)
	);

	// APB handshake
	assign idx     = paddr[6:2];
	assign pready  = psel && penable && ce && (bus_reg == BUS_HELD);
	assign wr_fire = pready && pwrite;
	assign rd_take = psel && ce && (bus_reg == BUS_IDLE);
	assign lane_m  = {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign prdata  = prdata_reg;
	assign pslverr = pready && err_reg;

	always_comb begin
		logic [1:0]  g;
		logic [23:0] pv;
		g           = idx[3:2];
		pv          = '0;
		bus_next    = bus_reg;
		prdata_next = prdata_reg;
		err_next    = err_reg;
		case (bus_reg)
			BUS_IDLE: begin
				if (rd_take) begin
					bus_next = BUS_HELD;
				end
			end
			BUS_HELD: begin
				if (pready || !psel) begin
					bus_next = BUS_IDLE;
				end
			end
			default: bus_next = BUS_IDLE;
		endcase
		if (rd_take) begin
			pv = (lines_sync[g*GROUP_LINES +: GROUP_LINES] & dir_lines(dir_reg[g]))
				| (latch_reg[g] & ~dir_lines(dir_reg[g]));
			prdata_next = 32'h00000000;
			err_next    = 1'b0;
			if (paddr[7] || idx > IDX_XEN1) begin
				err_next = 1'b1;
			end else if (!idx[4] && half_mode && idx[3]) begin
				prdata_next = 32'h00000000;
			end else if (!idx[4] && idx[1:0] == IDX_PORT_A[1:0]) begin
				prdata_next[7:0] = pv[OFS_A +: 8];
			end else if (!idx[4] && idx[1:0] == IDX_PORT_B[1:0]) begin
				prdata_next[7:0] = pv[OFS_B +: 8];
			end else if (!idx[4] && idx[1:0] == IDX_PORT_C[1:0]) begin
				prdata_next[7:0] = pv[OFS_CLO +: 8];
			end else if (idx == IDX_STAT_LO || idx == IDX_STAT_HI) begin
				prdata_next[7:0] = chi_get(flags, idx[0]);
			end else if (idx == IDX_EN_LO || idx == IDX_EN_HI) begin
				prdata_next[7:0] = chi_get(en_reg, idx[0]);
			end else if (idx == IDX_XSTAT0 || idx == IDX_XSTAT1) begin
				prdata_next[23:0] = flags[idx[0]*GROUP_LINES +: GROUP_LINES];
			end else if (idx == IDX_XEN0 || idx == IDX_XEN1) begin
				prdata_next[23:0] = en_reg[idx[0]*GROUP_LINES +: GROUP_LINES];
			end
		end
	end

	// Register writes
	always_comb begin
		logic [1:0] g;
		g       = idx[3:2];
		en_next = en_reg;
		clr     = '0;
		for (int k = 0; k < NUM_GROUPS; k++) begin
			dir_next[k]   = dir_reg[k];
			latch_next[k] = latch_reg[k];
		end
		if (wr_fire && !paddr[7]) begin
			if (!idx[4] && !(half_mode && idx[3]) && pstrb[0]) begin
				if (idx[1:0] == IDX_CMD[1:0] && pwdata[CW_MODE_SET]) begin
					dir_next[g][DIR_A]   = pwdata[CW_A_IN];
					dir_next[g][DIR_B]   = pwdata[CW_B_IN];
					dir_next[g][DIR_CHI] = pwdata[CW_CHI_IN];
					dir_next[g][DIR_CLO] = pwdata[CW_CLO_IN];
					latch_next[g]        = LATCH_RESET;
				end else if (idx[1:0] == IDX_CMD[1:0]) begin
					latch_next[g][OFS_CLO + 32'(pwdata[3:1])] = pwdata[0];
				end else if (idx[1:0] == IDX_PORT_A[1:0]) begin
					latch_next[g][OFS_A +: 8] = pwdata[7:0];
				end else if (idx[1:0] == IDX_PORT_B[1:0]) begin
					latch_next[g][OFS_B +: 8] = pwdata[7:0];
				end else begin
					latch_next[g][OFS_CLO +: 8] = pwdata[7:0];
				end
			end else if ((idx == IDX_STAT_LO || idx == IDX_STAT_HI) && pstrb[0]) begin
				if (pwdata[7:0] == 8'h00) begin
					clr = chi_map(8'hFF, idx[0]);
				end
			end else if ((idx == IDX_EN_LO || idx == IDX_EN_HI) && pstrb[0]) begin
				en_next = (en_reg & ~chi_map(8'hFF, idx[0])) | chi_map(pwdata[7:0], idx[0]);
			end else if (idx == IDX_XSTAT0 || idx == IDX_XSTAT1) begin
				if ((pwdata[23:0] & lane_m) == 24'h000000) begin
					clr[idx[0]*GROUP_LINES +: GROUP_LINES] = lane_m;
				end
			end else if (idx == IDX_XEN0 || idx == IDX_XEN1) begin
				en_next[idx[0]*GROUP_LINES +: GROUP_LINES] =
					(en_reg[idx[0]*GROUP_LINES +: GROUP_LINES] & ~lane_m) | (pwdata[23:0] & lane_m);
			end
		end
		if (half_mode) begin
			for (int k = HALF_GROUPS; k < NUM_GROUPS; k++) begin
				dir_next[k] = DIR_RESET;
			end
		end
		irq_next = |flags;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_reg    <= BUS_IDLE;
			prdata_reg <= 32'h00000000;
			err_reg    <= 1'b0;
			en_reg     <= EN_RESET;
			irq_reg    <= 1'b0;
			for (int k = 0; k < NUM_GROUPS; k++) begin
				dir_reg[k]   <= DIR_RESET;
				latch_reg[k] <= LATCH_RESET;
			end
		end else if (ce) begin
			bus_reg    <= bus_next;
			prdata_reg <= prdata_next;
			err_reg    <= err_next;
			en_reg     <= en_next;
			irq_reg    <= irq_next;
			for (int k = 0; k < NUM_GROUPS; k++) begin
				dir_reg[k]   <= dir_next[k];
				latch_reg[k] <= latch_next[k];
			end
		end
	end

	// Output drive follows direction bits
	always_comb begin
		for (int g = 0; g < NUM_GROUPS; g++) begin
			io_o[g*GROUP_LINES +: GROUP_LINES] = latch_reg[g];
		end
	end
	assign io_oe_n = dir_all;
	assign irq     = irq_reg;

	a_reset_inputs: assert property (@(posedge clk) $past(rst) |-> &io_oe_n)
		else $error("line driven after reset");
	a_dir_follow: assert property (@(posedge clk) disable iff (rst)
		(wr_fire && idx == IDX_CMD && pstrb[0] && pwdata[CW_MODE_SET] && !paddr[7])
		|=> io_oe_n[7:0] == {8{$past(pwdata[CW_A_IN])}} && io_oe_n[23:20] == {4{$past(pwdata[CW_CHI_IN])}})
		else $error("buffer direction not following control word");
	a_out_readback: assert property (@(posedge clk) disable iff (rst)
		(rd_take && idx[1:0] == IDX_PORT_B[1:0] && idx < IDX_STAT_LO && !paddr[7]
		&& !(half_mode && idx[3]) && !dir_reg[idx[3:2]][DIR_B])
		|=> prdata[7:0] == $past(latch_reg[idx[3:2]][OFS_B +: 8]))
		else $error("output port read not from latch");
	a_irq_level: assert property (@(posedge clk) disable iff (rst)
		(ce && |flags) |=> irq ##0 int_oe_n[sel_idx] == 1'b0)
		else $error("interrupt not raised for flag");
	a_mask_gate: assert property (@(posedge clk) disable iff (rst)
		$past(ce) |-> ((flags & ~$past(flags)) & ~$past(det_en)) == '0)
		else $error("flag set on disabled line");
	a_half_idle: assert property (@(posedge clk) disable iff (rst)
		$past(half_mode) && $past(ce) |-> &io_oe_n[NUM_LINES-1:HALF_GROUPS*GROUP_LINES])
		else $error("upper groups driven in reduced variant");
	a_sel_route: assert property (@(posedge clk) disable iff (rst)
		($past(ce) && $past(ce, 2) && $past(sw_sel1_i, 2) == $past(sw_sel1_i, 3)
		&& $past(sw_sel2_i, 2) == $past(sw_sel2_i, 3))
		|-> sel_idx == {$past(sw_sel2_i, 2), $past(sw_sel1_i, 2)})
		else $error("group index not from switches");
	a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
		(pready && (paddr[7] || idx > IDX_XEN1)) |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	a_one_wait: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && ce && bus_reg == BUS_IDLE) ##1 (psel && penable && ce) |-> pready)
		else $error("access phase not answered");
endmodule

// ==== rtl/pio_pkg.sv ====
// Constants, register indices and field layout for the parallel I/O block.
// Assumes a 40 MHz clock and an APB slave with 32-bit data.
package pio_pkg;

	localparam int NUM_GROUPS  = 4;
	localparam int GROUP_LINES = 24;
	localparam int NUM_LINES   = 96;
	localparam int HALF_GROUPS = 2;

	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_PORT_A  = 5'h00;
	localparam logic [4:0] IDX_PORT_B  = 5'h01;
	localparam logic [4:0] IDX_PORT_C  = 5'h02;
	localparam logic [4:0] IDX_CMD     = 5'h03;
	localparam logic [4:0] IDX_STAT_LO = 5'h10;
	localparam logic [4:0] IDX_STAT_HI = 5'h11;
	localparam logic [4:0] IDX_EN_LO   = 5'h12;
	localparam logic [4:0] IDX_EN_HI   = 5'h13;
	localparam logic [4:0] IDX_XSTAT0  = 5'h14;
	localparam logic [4:0] IDX_XSTAT1  = 5'h15;
	localparam logic [4:0] IDX_XEN0    = 5'h16;
	localparam logic [4:0] IDX_XEN1    = 5'h17;

	// Control word fields
	localparam int CW_MODE_SET = 7;
	localparam int CW_A_IN     = 4;
	localparam int CW_CHI_IN   = 3;
	localparam int CW_B_IN     = 1;
	localparam int CW_CLO_IN   = 0;

	// Direction bits per group, 1 means input
	localparam int DIR_A   = 3;
	localparam int DIR_B   = 2;
	localparam int DIR_CHI = 1;
	localparam int DIR_CLO = 0;

	// Line offsets inside a group
	localparam int OFS_A   = 0;
	localparam int OFS_B   = 8;
	localparam int OFS_CLO = 16;
	localparam int OFS_CHI = 20;

	// Reset values
	localparam logic [3:0]           DIR_RESET   = 4'hF;
	localparam logic [23:0]          LATCH_RESET = 24'h000000;
	localparam logic [NUM_LINES-1:0] EN_RESET    = 96'h0;

	// Change qualifying time
	localparam int QUAL_TIME_NS  = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int QUAL_CYC      = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUAL_W        = 6;
	localparam logic [QUAL_W-1:0] QUAL_CYC_M1 = QUAL_W'(QUAL_CYC - 1);

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_HELD = 1'b1
	} bus_state_t;

endpackage

// ==== rtl/sync_2ff.sv ====
// Two-flop synchronizer for pins arriving from outside the clock domain.
// Assumes inputs are quasi-static or slow relative to clk.
`timescale 1ns/100ps
module sync_2ff #(
	parameter int W = 1
) (
	// Clock and control
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s1_next;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s2_next;

	always_comb begin
		s1_next = d;
		s2_next = s1_reg;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else if (ce) begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
		end
	end

	assign q = s2_reg;
endmodule

// ==== rtl/change_detector.sv ====
// Per-line level change detector with qualifying time and reference.
// Assumes line levels are already synchronized to clk.
`timescale 1ns/100ps
module change_detector
	import pio_pkg::*;
(
	// Clock and control
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Lines and control
	input  wire logic [NUM_LINES-1:0] line_lvl,
	input  wire logic [NUM_LINES-1:0] det_en,
	input  wire logic [NUM_LINES-1:0] clr,
	// Status
	output logic      [NUM_LINES-1:0] flag
);
	logic [NUM_LINES-1:0] ref_reg;
	logic [NUM_LINES-1:0] ref_next;
	logic [NUM_LINES-1:0] flag_reg;
	logic [NUM_LINES-1:0] flag_next;
	logic [NUM_LINES-1:0] set_vec;
	logic [QUAL_W-1:0]    cnt_reg  [NUM_LINES];
	logic [QUAL_W-1:0]    cnt_next [NUM_LINES];

	always_comb begin
		ref_next  = ref_reg;
		flag_next = flag_reg;
		set_vec   = '0;
		for (int i = 0; i < NUM_LINES; i++) begin
			cnt_next[i] = cnt_reg[i];
			if (!det_en[i]) begin
				ref_next[i] = line_lvl[i];
				cnt_next[i] = '0;
			end else if (line_lvl[i] != ref_reg[i]) begin
				// Count parks past the limit: one set per lasting change
				if (cnt_reg[i] == QUAL_CYC_M1) begin
					set_vec[i]  = 1'b1;
					cnt_next[i] = cnt_reg[i] + 1'b1;
				end else if (cnt_reg[i] < QUAL_CYC_M1) begin
					cnt_next[i] = cnt_reg[i] + 1'b1;
				end
			end else begin
				cnt_next[i] = '0;
			end
			if (clr[i]) begin
				ref_next[i] = line_lvl[i];
				cnt_next[i] = '0;
			end
			flag_next[i] = set_vec[i] | (flag_reg[i] & ~clr[i]);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ref_reg  <= '0;
			flag_reg <= '0;
			for (int i = 0; i < NUM_LINES; i++) begin
				cnt_reg[i] <= '0;
			end
		end else if (ce) begin
			ref_reg  <= ref_next;
			flag_reg <= flag_next;
			for (int i = 0; i < NUM_LINES; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
		end
	end

	assign flag = flag_reg;

	a_flag_persist: assert property (@(posedge clk) disable iff (rst)
		(!flag_reg[20] ##1 flag_reg[20]) |-> $past(cnt_reg[20]) == QUAL_CYC_M1)
		else $error("flag set before qualifying time");
	a_clear_drops: assert property (@(posedge clk) disable iff (rst)
		(clr[20] && ce && !set_vec[20]) |=> !flag_reg[20])
		else $error("flag not cleared");
endmodule

// ==== verification/apb_host.sv ====
// Host model: issues one APB register transfer at a time.
// Assumes a slave that answers with pready; one idle cycle between transfers.
`timescale 1ns/100ps
module apb_host (
	// Clock
	input  wire logic        clk,
	// Request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	// Answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic hung;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		pstrb   = 4'h0;
		hung    = 1'b0;
	end

	// Word transfer by register index, request held until pready
	task automatic xfer(input logic w, input logic [4:0] idx, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {1'b0, idx, 2'b00};
		pwdata  <= d;
		pstrb   <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 64) begin
			@(posedge clk);
			n++;
		end
		hung = (pready !== 1'b1);
		rd   = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ==== verification/test_parallel_io_change_detect.sv ====
// Self-checking bench for the parallel I/O block with change detect.
// Assumes pulled-up pins; the host model drives the register bus.
`timescale 1ns/100ps
module test_parallel_io_change_detect;
	import pio_pkg::*;
	logic                 clk, rst, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata;
	logic [3:0]           pstrb, grp_clk_i, grp_idsel_i, int_o, int_oe_n;
	logic [NUM_LINES-1:0] ext, io_o, io_oe_n;
	wire  [NUM_LINES-1:0] io_i;
	logic                 sw_sel1_i, sw_sel2_i, half_width_i, detect_all_i;
	logic                 sel_clk_o, sel_idsel_o, irq;
	int                   err_total, n_tests;

	// Pins: driven by the block where enabled, else pulled up or driven by ext
	assign io_i = (io_oe_n & ext) | (~io_oe_n & io_o);

	apb_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	parallel_io_change_detect dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.io_i(io_i), .io_o(io_o), .io_oe_n(io_oe_n), .sw_sel1_i(sw_sel1_i),
		.sw_sel2_i(sw_sel2_i), .half_width_i(half_width_i), .detect_all_i(detect_all_i),
		.grp_clk_i(grp_clk_i), .grp_idsel_i(grp_idsel_i), .sel_clk_o(sel_clk_o),
		.sel_idsel_o(sel_idsel_o), .int_o(int_o), .int_oe_n(int_oe_n), .irq(irq));

	always #12.5 clk = ~clk;

	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		host.xfer(1'b1, idx, d, r, e);
		chk("write error", 96'(0), 96'(e | host.hung));
	endtask

	task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		host.xfer(1'b0, idx, 32'h00000000, r, e);
		chk("read error", 96'(0), 96'(e | host.hung));
		chk("read data", 96'(exp), 96'(r));
	endtask

	task automatic settle();
		@(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic t_reset();
		logic [4:0] en_idx [4] = '{IDX_EN_LO, IDX_EN_HI, IDX_XEN0, IDX_XEN1};
		chk("oe_n", {NUM_LINES{1'b1}}, io_oe_n);
		chk("io_o", 96'(0), io_o);
		chk("irq", 96'(0), 96'(irq));
		chk("int_o", 96'(0), 96'(int_o));
		chk("int_oe_n", 96'(4'hF), 96'(int_oe_n));
		for (int i = 0; i < 4; i++)
			rd(en_idx[i], 32'h00000000);
		rd(IDX_PORT_A, 32'h000000FF);
	endtask

	task automatic t_dir();
		logic [7:0]  bitpos [4] = '{8'h10, 8'h02, 8'h01, 8'h08};
		logic [23:0] mask [4]   = '{24'h0000FF, 24'h00FF00, 24'h0F0000, 24'hF00000};
		for (int g = 0; g < 4; g++) begin
			for (int p = 0; p < 4; p++) begin
				wr(5'(4 * g + 3), 32'(8'h9B & ~bitpos[p]));
				settle();
				chk("oe_n", ~(96'(mask[p]) << (24 * g)), io_oe_n);
			end
			wr(5'(4 * g + 3), 32'h0000009B);
		end
	endtask

	task automatic t_latch();
		wr(5'h07, 32'h00000080);
		wr(5'h04, 32'h0000005A);
		wr(5'h05, 32'h000000C3);
		wr(5'h06, 32'h00000096);
		wr(5'h07, 32'h0000000E);
		settle();
		chk("io_o", {48'h0, 24'h16C35A, 24'h0}, io_o);
		rd(5'h04, 32'h0000005A);
		rd(5'h05, 32'h000000C3);
		rd(5'h06, 32'h00000016);
		rd(5'h07, 32'h00000000);
		wr(5'h07, 32'h0000009B);
	endtask

	task automatic t_half();
		half_width_i <= 1'b1;
		repeat (3) @(posedge clk);
		wr(5'h0B, 32'h00000080);
		settle();
		chk("oe_n", {NUM_LINES{1'b1}}, io_oe_n);
		rd(5'h08, 32'h00000000);
		wr(IDX_XEN0, 32'h00000001);
		ext[0] <= 1'b0;
		repeat (50) @(posedge clk);
		chk("irq half", 96'(0), 96'(irq));
		ext[0] <= 1'b1;
		wr(IDX_XEN0, 32'h00000000);
		half_width_i <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_cos();
		wr(IDX_STAT_LO, 32'h00000000);
		wr(IDX_EN_LO, 32'h00000001);
		ext[20] <= 1'b0;
		repeat (30) @(posedge clk);
		ext[20] <= 1'b1;
		repeat (50) @(posedge clk);
		chk("irq glitch", 96'(0), 96'(irq));
		ext[20] <= 1'b0;
		ext[21] <= 1'b0;
		repeat (38) @(posedge clk);
		chk("irq early", 96'(0), 96'(irq));
		wait_irq(12);
		chk("irq", 96'(1), 96'(irq));
		chk("int_oe_n", 96'(4'hE), 96'(int_oe_n));
		rd(IDX_STAT_LO, 32'h00000001);
		wr(IDX_STAT_LO, 32'h00000000);
		settle();
		chk("irq clear", 96'(0), 96'(irq));
		chk("int_oe_n", 96'(4'hF), 96'(int_oe_n));
		repeat (60) @(posedge clk);
		chk("irq reload", 96'(0), 96'(irq));
		wr(IDX_EN_LO, 32'h00000000);
		ext[20] <= 1'b1;
		ext[21] <= 1'b1;
		repeat (5) @(posedge clk);
		wr(IDX_STAT_LO, 32'h00000000);
	endtask

	task automatic t_mux();
		grp_clk_i   <= 4'hA;
		grp_idsel_i <= 4'h5;
		for (int i = 0; i < 4; i++) begin
			sw_sel1_i <= i[0];
			sw_sel2_i <= i[1];
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk("clk sel", 96'((4'hA >> i) & 4'h1), 96'(sel_clk_o));
			chk("idsel sel", 96'((4'h5 >> i) & 4'h1), 96'(sel_idsel_o));
		end
		sw_sel1_i <= 1'b0;
		sw_sel2_i <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_unmapped();
		logic [31:0] r;
		logic        e;
		host.xfer(1'b0, 5'h18, 32'h00000000, r, e);
		chk("slverr", 96'(1), 96'(e));
		chk("unmapped data", 96'(0), 96'(r));
		host.xfer(1'b1, 5'h18, 32'h000000FF, r, e);
		chk("slverr", 96'(1), 96'(e));
	endtask

	task automatic t_all();
		half_width_i <= 1'b1;
		detect_all_i <= 1'b1;
		repeat (3) @(posedge clk);
		wr(IDX_XSTAT0, 32'h00000000);
		wr(IDX_XEN0, 32'h00000001);
		ext[0] <= 1'b0;
		wait_irq(60);
		chk("irq all", 96'(1), 96'(irq));
		rd(IDX_XSTAT0, 32'h00000001);
		wr(IDX_XEN0, 32'h00000000);
		ext[0] <= 1'b1;
		repeat (5) @(posedge clk);
		wr(IDX_XSTAT0, 32'h00000000);
		settle();
		chk("irq all clear", 96'(0), 96'(irq));
		half_width_i <= 1'b0;
		detect_all_i <= 1'b0;
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		summarize();
	end

	initial begin
		clk          = 1'b0;
		rst          = 1'b1;
		ce           = 1'b1;
		ext          = {NUM_LINES{1'b1}};
		sw_sel1_i    = 1'b0;
		sw_sel2_i    = 1'b0;
		half_width_i = 1'b0;
		detect_all_i = 1'b0;
		grp_clk_i    = 4'h0;
		grp_idsel_i  = 4'h0;
		err_total    = 0;
		n_tests      = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_dir();
		t_latch();
		t_half();
		t_cos();
		t_mux();
		t_unmapped();
		t_all();
		summarize();
	end
endmodule
